// file: core/ptoer_regs.sv
`include "ptoer_map.svh"

// Notes on behaviour
// R01: Parity error count is 8 bits, saturates at 0xFF, read clears it.
// R02: Time-out enable bit 0 resets to 1 and is sticky.
// R03: With time-outs enabled, packets overdue in the input queue are dropped.
// R04: Bits 1:0 pick posted time-out reporting, reset value 2 (nonfatal).
// R05: Bits 3:2 pick non-posted time-out reporting, reset value 0 (none).
// R06: Bits 5:4 pick completion time-out reporting, reset value 0 (none).
// R07: Field 0 none, 1 correctable, 2 nonfatal, 3 fatal message to root.
// R08: Report only on a 0-to-1 change of the matching status bit.
// R09: Posted drops counted in bits 7:0, saturating, read clears.
// R10: Non-posted drops counted in bits 15:8, saturating, read clears.
// R11: Completion drops counted in bits 23:16, saturating, read clears.
// R12: Wakeup bit 0 gates the wake output, reset value 1.
// R13: Wakeup bit 1 gates in-band beacon signalling, reset value 1.
// R14: Sticky fields survive hot reset; reserved bits read zero, ignore writes.
module ptoer_regs #(
  parameter int ADDR_WIDTH = 12,
  parameter int CNT_WIDTH  = 8,
  parameter int NUM_QUEUES = 3
) (
  // Clock, enable and resets
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic                     clk_en,
  input  wire logic                     fund_reset,
  input  wire logic                     hot_reset,
  // APB slave
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [ADDR_WIDTH-1:0]    paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  // Switch core events
  input  wire logic                     parity_err,
  input  wire logic [NUM_QUEUES-1:0]    queue_head_expired,
  input  wire logic [NUM_QUEUES-1:0]    timeout_status,
  // Input queue drop commands
  output logic      [NUM_QUEUES-1:0]    queue_drop,
  output logic                          timeout_enable,
  // Error message requests toward the root
  output logic                          err_cor_req,
  output logic                          err_nonfatal_req,
  output logic                          err_fatal_req,
  // Wake pin, open drain
  input  wire logic                     wake_req,
  input  wire logic                     wake_in,
  output logic                          wake_out,
  output logic                          wake_oe_n,
  // Beacon
  input  wire logic                     beacon_req,
  output logic                          beacon_send,
  output logic                          beacon_enable
);
  import ptoer_pkg::*;

  localparam int RW = 2 * NUM_QUEUES;

  // Bus state
  ptoer_bus_state_type   bus_state_q;
  ptoer_bus_state_type   bus_state_d;
  logic [31:0]           prdata_q;
  logic [31:0]           prdata_d;
  logic                  pslverr_q;
  logic                  pslverr_d;
  logic                  pready_q;
  logic                  pready_d;
  logic                  rd_take;
  logic                  wr_take;
  logic                  hit;
  logic [31:0]           rd_value;

  // Configuration state
  logic                  to_en_q;
  logic                  to_en_d;
  logic [RW-1:0]         report_q;
  logic [RW-1:0]         report_d;
  logic                  wake_en_q;
  logic                  wake_en_d;
  logic                  beacon_en_q;
  logic                  beacon_en_d;

  // Event state
  logic [NUM_QUEUES-1:0] drop_q;
  logic [NUM_QUEUES-1:0] drop_d;
  logic [NUM_QUEUES-1:0] status_prev_q;
  logic [NUM_QUEUES-1:0] status_prev_d;
  logic                  cor_q;
  logic                  cor_d;
  logic                  nonfatal_q;
  logic                  nonfatal_d;
  logic                  fatal_q;
  logic                  fatal_d;
  logic [NUM_QUEUES-1:0] rise;

  // Wake and beacon state
  logic [2:0]            wake_sync_q;
  logic [2:0]            wake_sync_d;
  logic                  wake_pin_q;
  logic                  wake_pin_d;
  logic                  wake_oe_n_q;
  logic                  wake_oe_n_d;
  logic                  wake_out_q;
  logic                  beacon_q;
  logic                  beacon_d;

  // Counters
  logic [CNT_WIDTH-1:0]  parity_cnt;
  logic [CNT_WIDTH-1:0]  drop_cnt [NUM_QUEUES];
  logic                  clr_parity;
  logic                  clr_drop;

  // Bus decode; one wait state, reads sampled and cleared as pready rises
  assign rd_take  = psel && penable && !pwrite
                    && (bus_state_q == PTOER_BUS_IDLE);
  assign wr_take  = psel && penable && pwrite
                    && (bus_state_q == PTOER_BUS_READY);

  always_comb begin
    hit      = 1'b1;
    rd_value = `PTOER_RST_DATA;
    case (paddr)
      `PTOER_OFF_PARITY_CNT: begin
        rd_value[CNT_WIDTH-1:0] = parity_cnt;                     // [R01]
      end
      `PTOER_OFF_TO_ENABLE: begin
        rd_value[`PTOER_TO_EN_BIT] = to_en_q;
      end
      `PTOER_OFF_TO_REPORT: begin
        rd_value[RW-1:0] = report_q;
      end
      `PTOER_OFF_DROP_CNT: begin
        rd_value[`PTOER_POSTED_CNT_LSB +: CNT_WIDTH] =
          drop_cnt[PTOER_Q_POSTED];                                // [R09]
        rd_value[`PTOER_NONPOST_CNT_LSB +: CNT_WIDTH] =
          drop_cnt[PTOER_Q_NONPOST];                               // [R10]
        rd_value[`PTOER_CPL_CNT_LSB +: CNT_WIDTH] =
          drop_cnt[PTOER_Q_CPL];                                   // [R11]
      end
      `PTOER_OFF_WAKE_CTRL: begin
        rd_value[`PTOER_WAKE_EN_BIT]   = wake_en_q;
        rd_value[`PTOER_BEACON_EN_BIT] = beacon_en_q;
      end
      `PTOER_OFF_WAKE_STATUS: begin
        rd_value[`PTOER_WAKE_PIN_BIT] = wake_pin_q;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  assign clr_parity = rd_take && (paddr == `PTOER_OFF_PARITY_CNT);
  assign clr_drop   = rd_take && (paddr == `PTOER_OFF_DROP_CNT);

  always_comb begin
    bus_state_d = bus_state_q;
    prdata_d    = prdata_q;
    pslverr_d   = pslverr_q;
    case (bus_state_q)
      PTOER_BUS_IDLE: begin
        if (psel && penable) begin
          bus_state_d = PTOER_BUS_READY;
          pslverr_d   = !hit;
          prdata_d    = pwrite ? `PTOER_RST_DATA : rd_value;
        end
      end
      PTOER_BUS_READY: begin
        bus_state_d = PTOER_BUS_IDLE;
        pslverr_d   = 1'b0;
        prdata_d    = `PTOER_RST_DATA;
      end
      default: begin
        bus_state_d = PTOER_BUS_IDLE;
      end
    endcase
    pready_d = (bus_state_d == PTOER_BUS_READY);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_state_q <= PTOER_BUS_IDLE;
      prdata_q    <= `PTOER_RST_DATA;
      pslverr_q   <= 1'b0;
      pready_q    <= 1'b0;
    end else if (clk_en) begin
      bus_state_q <= bus_state_d;
      prdata_q    <= prdata_d;
      pslverr_q   <= pslverr_d;
      pready_q    <= pready_d;
    end
  end

  // Configuration: sticky fields reset only on power-on; fundamental reset also restores time-out enable and reporting
  always_comb begin
    to_en_d     = to_en_q;
    report_d    = report_q;
    wake_en_d   = wake_en_q;
    beacon_en_d = beacon_en_q;
    if (fund_reset) begin
      to_en_d  = `PTOER_RST_TO_EN;                                 // [R02] [R14]
      report_d[`PTOER_POSTED_REP_LSB +: 2]  = `PTOER_RST_POSTED_REP;  // [R04]
      report_d[`PTOER_NONPOST_REP_LSB +: 2] = `PTOER_RST_NONPOST_REP; // [R05]
      report_d[`PTOER_CPL_REP_LSB +: 2]     = `PTOER_RST_CPL_REP;     // [R06]
    end else if (wr_take) begin
      case (paddr)
        `PTOER_OFF_TO_ENABLE: begin
          to_en_d = pwdata[`PTOER_TO_EN_BIT];                      // [R02]
        end
        `PTOER_OFF_TO_REPORT: begin
          report_d = pwdata[RW-1:0];                               // [R14]
        end
        `PTOER_OFF_WAKE_CTRL: begin
          wake_en_d   = pwdata[`PTOER_WAKE_EN_BIT];                // [R12]
          beacon_en_d = pwdata[`PTOER_BEACON_EN_BIT];              // [R13]
        end
        default: begin
          to_en_d = to_en_q;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      to_en_q     <= `PTOER_RST_TO_EN;                             // [R02]
      report_q    <= {`PTOER_RST_CPL_REP, `PTOER_RST_NONPOST_REP,
                      `PTOER_RST_POSTED_REP};                      // [R04]
      wake_en_q   <= `PTOER_RST_WAKE_EN;                           // [R12]
      beacon_en_q <= `PTOER_RST_BEACON_EN;                         // [R13]
    end else if (clk_en) begin
      to_en_q     <= to_en_d;
      report_q    <= report_d;
      wake_en_q   <= wake_en_d;
      beacon_en_q <= beacon_en_d;
    end
  end

  // Drops and time-out reports
  assign rise = timeout_status & ~status_prev_q;                   // [R08]

  always_comb begin
    drop_d        = '0;
    status_prev_d = timeout_status;
    cor_d         = 1'b0;
    nonfatal_d    = 1'b0;
    fatal_d       = 1'b0;
    if (to_en_q) begin
      drop_d = queue_head_expired & ~drop_q;                       // [R03]
    end
    for (int i = 0; i < NUM_QUEUES; i++) begin
      if (rise[i]) begin
        case (ptoer_sev_type'(report_q[2*i +: 2]))                // [R07]
          PTOER_SEV_COR: begin
            cor_d = 1'b1;
          end
          PTOER_SEV_NONFATAL: begin
            nonfatal_d = 1'b1;
          end
          PTOER_SEV_FATAL: begin
            fatal_d = 1'b1;
          end
          default: begin
            cor_d = cor_d;
          end
        endcase
      end
    end
    if (hot_reset || fund_reset) begin
      drop_d     = '0;
      cor_d      = 1'b0;
      nonfatal_d = 1'b0;
      fatal_d    = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      drop_q        <= '0;
      status_prev_q <= '0;
      cor_q         <= 1'b0;
      nonfatal_q    <= 1'b0;
      fatal_q       <= 1'b0;
    end else if (clk_en) begin
      drop_q        <= drop_d;
      status_prev_q <= status_prev_d;
      cor_q         <= cor_d;
      nonfatal_q    <= nonfatal_d;
      fatal_q       <= fatal_d;
    end
  end

  // Counters
  ptoer_sat_counter #(
    .WIDTH (CNT_WIDTH)
  ) u_parity_cnt (
    .clk    (clk),
    .rst_n  (rst_n),
    .clk_en (clk_en),
    .init   (fund_reset),
    .inc    (parity_err),                                          // [R01]
    .clr    (clr_parity),                                          // [R01]
    .count  (parity_cnt)
  );

  for (genvar g = 0; g < NUM_QUEUES; g++) begin : g_drop_cnt
    ptoer_sat_counter #(
      .WIDTH (CNT_WIDTH)
    ) u_drop_cnt (
      .clk    (clk),
      .rst_n  (rst_n),
      .clk_en (clk_en),
      .init   (fund_reset),
      .inc    (drop_q[g]),                                 // [R09] [R10] [R11]
      .clr    (clr_drop),                                  // [R09] [R10] [R11]
      .count  (drop_cnt[g])
    );
  end

  // Wake pin and beacon; pin level counts once sync stages two and three agree
  always_comb begin
    wake_sync_d = {wake_sync_q[1:0], wake_in};
    wake_pin_d  = wake_pin_q;
    if (wake_sync_q[1] == wake_sync_q[2]) begin
      wake_pin_d = wake_sync_q[2];
    end
    wake_oe_n_d = !(wake_req && wake_en_q);                        // [R12]
    beacon_d    = beacon_req && beacon_en_q;                       // [R13]
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_sync_q <= 3'h7;
      wake_pin_q  <= 1'b1;
      wake_oe_n_q <= 1'b1;
      wake_out_q  <= 1'b0;
      beacon_q    <= 1'b0;
    end else if (clk_en) begin
      wake_sync_q <= wake_sync_d;
      wake_pin_q  <= wake_pin_d;
      wake_oe_n_q <= wake_oe_n_d;
      wake_out_q  <= 1'b0;
      beacon_q    <= beacon_d;
    end
  end

  // Outputs
  assign prdata           = prdata_q;
  assign pready           = pready_q;
  assign pslverr          = pslverr_q;
  assign queue_drop       = drop_q;
  assign timeout_enable   = to_en_q;
  assign err_cor_req      = cor_q;
  assign err_nonfatal_req = nonfatal_q;
  assign err_fatal_req    = fatal_q;
  assign wake_out         = wake_out_q;
  assign wake_oe_n        = wake_oe_n_q;
  assign beacon_send      = beacon_q;
  assign beacon_enable    = beacon_en_q;

endmodule : ptoer_regs

// file: core/ptoer_sat_counter.sv
// Saturating event counter with clear; an event in the clear cycle survives
module ptoer_sat_counter #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             clk_en,
  // Control
  input  wire logic             init,
  input  wire logic             inc,
  input  wire logic             clr,
  // Value
  output logic [WIDTH-1:0]      count
);

  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] count_d;

  always_comb begin
    count_d = count_q;
    if (init) begin
      count_d = '0;
    end else if (clr) begin
      count_d = inc ? WIDTH'(1) : '0;
    end else if (inc && (count_q != {WIDTH{1'b1}})) begin
      count_d = count_q + WIDTH'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= '0;
    end else if (clk_en) begin
      count_q <= count_d;
    end
  end

  assign count = count_q;

endmodule : ptoer_sat_counter

// file: pkg/ptoer_map.svh
`ifndef PTOER_MAP_SVH
`define PTOER_MAP_SVH

// Register byte offsets
`define PTOER_OFF_PARITY_CNT   12'h04e0
`define PTOER_OFF_TO_ENABLE    12'h04e4
`define PTOER_OFF_TO_REPORT    12'h04e8
`define PTOER_OFF_DROP_CNT     12'h04ec
`define PTOER_OFF_WAKE_CTRL    12'h05cc
`define PTOER_OFF_WAKE_STATUS  12'h05d0

// Field positions
`define PTOER_TO_EN_BIT        0
`define PTOER_POSTED_REP_LSB   0
`define PTOER_NONPOST_REP_LSB  2
`define PTOER_CPL_REP_LSB      4
`define PTOER_POSTED_CNT_LSB   0
`define PTOER_NONPOST_CNT_LSB  8
`define PTOER_CPL_CNT_LSB      16
`define PTOER_WAKE_EN_BIT      0
`define PTOER_BEACON_EN_BIT    1
`define PTOER_WAKE_PIN_BIT     0

// Reset values
`define PTOER_RST_TO_EN        1'h1
`define PTOER_RST_POSTED_REP   2'h2
`define PTOER_RST_NONPOST_REP  2'h0
`define PTOER_RST_CPL_REP      2'h0
`define PTOER_RST_WAKE_EN      1'h1
`define PTOER_RST_BEACON_EN    1'h1
`define PTOER_RST_DATA         32'h0000_0000

`endif

// file: pkg/ptoer_pkg.sv
package ptoer_pkg;

  // Error message severity carried in each reporting field
  typedef enum logic [1:0] {
    PTOER_SEV_NONE     = 2'b00,
    PTOER_SEV_COR      = 2'b01,
    PTOER_SEV_NONFATAL = 2'b10,
    PTOER_SEV_FATAL    = 2'b11
  } ptoer_sev_type;

  // Bus slave phase
  typedef enum logic [1:0] {
    PTOER_BUS_IDLE  = 2'b00,
    PTOER_BUS_READY = 2'b01
  } ptoer_bus_state_type;

  // Queue index: posted, non-posted, completion
  typedef enum logic [1:0] {
    PTOER_Q_POSTED  = 2'b00,
    PTOER_Q_NONPOST = 2'b01,
    PTOER_Q_CPL     = 2'b10
  } ptoer_queue_type;

endpackage : ptoer_pkg

// file: tb/ptoer_core_model.sv
// Switch core side: overdue packets wait at the queue heads until dropped
module ptoer_core_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Drop commands from the port
  input  wire logic [2:0] queue_drop,
  // Bench loads overdue packets into one queue
  input  wire logic       add_stb,
  input  wire logic [1:0] add_q,
  input  wire logic [8:0] add_n,
  // Head packet overdue
  output logic      [2:0] queue_head_expired
);
  timeunit 1ns;
  timeprecision 100ps;
  int pend [3];

  always @(posedge clk or negedge rst_n) begin
    for (int i = 0; i < 3; i++) begin
      if (!rst_n) pend[i] <= 0;
      else pend[i] <= pend[i] - int'(queue_drop[i])
        + ((add_stb && add_q == 2'(i)) ? int'(add_n) : 0);
    end
  end

  always_comb begin
    for (int i = 0; i < 3; i++) queue_head_expired[i] = pend[i] != 0;
  end
endmodule : ptoer_core_model

// file: tb/ptoer_regs_chk.sv
module ptoer_regs_chk (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       clk_en,
  input wire logic       hot_reset,
  // Bus
  input wire logic       pready,
  input wire logic       pslverr,
  // Queues and reports
  input wire logic [2:0] queue_head_expired,
  input wire logic [2:0] timeout_status,
  input wire logic [2:0] queue_drop,
  input wire logic       timeout_enable,
  input wire logic       err_cor_req,
  input wire logic       err_nonfatal_req,
  input wire logic       err_fatal_req,
  // Wake and beacon
  input wire logic       wake_req,
  input wire logic       wake_out,
  input wire logic       wake_oe_n,
  input wire logic       beacon_req,
  input wire logic       beacon_send,
  input wire logic       beacon_enable
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] st_q;
  logic [2:0] rise;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) st_q <= 3'h0;
    else st_q <= timeout_status;
  end
  assign rise = timeout_status & ~st_q;

  a_ready_err: assert property (pslverr |-> pready)
    else $error("error response without ready");
  a_drop_cause: assert property (queue_drop != 3'h0 |->
    $past(timeout_enable) && (queue_drop & ~$past(queue_head_expired)) == 3'h0)
    else $error("drop without enabled overdue head");
  a_drop_due: assert property (clk_en && timeout_enable
    && queue_head_expired[1] && !queue_drop[1] && !hot_reset
    |=> queue_drop[1])
    else $error("overdue head not dropped");
  a_report_rise: assert property ((err_cor_req || err_nonfatal_req
    || err_fatal_req) |-> $past(rise != 3'h0))
    else $error("report without status rise");
  a_en_reset: assert property ($rose(rst_n) |->
    timeout_enable && beacon_enable)
    else $error("enable bits wrong after reset");
  a_wake_gate: assert property (!wake_oe_n |-> $past(wake_req))
    else $error("wake pin pulled without request");
  a_wake_low: assert property (wake_out == 1'b0)
    else $error("wake pin driven high");
  a_beacon_gate: assert property ($past(rst_n && clk_en) |->
    beacon_send == $past(beacon_req && beacon_enable))
    else $error("beacon not gated by enable");

  cover property (err_fatal_req);
  cover property (queue_drop == 3'h4);
  cover property (pslverr);
endmodule : ptoer_regs_chk

bind ptoer_regs ptoer_regs_chk u_chk (.*);

// file: tb/ptoer_regs_tb.sv
`include "ptoer_map.svh"

module ptoer_regs_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1;
  logic        fund_reset = 1'b0, hot_reset = 1'b0, parity_err = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        wake_req = 1'b0, wake_in = 1'b1, beacon_req = 1'b0;
  logic        add_stb = 1'b0;
  logic [1:0]  add_q = 2'h0;
  logic [8:0]  add_n = 9'h000;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [2:0]  timeout_status = 3'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, timeout_enable, wake_out, wake_oe_n;
  logic        err_cor_req, err_nonfatal_req, err_fatal_req;
  logic        beacon_send, beacon_enable;
  logic [2:0]  queue_drop, queue_head_expired, msg;
  logic [32:0] exp_rd [$];
  logic [2:0]  exp_msg [$];
  int          num_errors = 0;
  int          n_compared = 0;

  always #2.5 clk = ~clk;
  assign msg = {err_fatal_req, err_nonfatal_req, err_cor_req};

  ptoer_regs uut (.*);
  ptoer_core_model u_core (.*);

  task conclude;
    $display("compares %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude

  task chk(input string nm, input logic [32:0] seen, input logic [32:0] e);
    n_compared++;
    if (seen !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, seen);
    end
  endtask : chk

  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  // Check a level wait's count against its bound; running out ends the run
  task bound(input int i);
    if (i >= 2000) begin
      num_errors++;
      conclude();
    end
  endtask : bound

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 2000);
    bound(i);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task rd(input logic [11:0] a, input logic [32:0] e);
    exp_rd.push_back(e);
    apb(1'b0, a, 32'h0000_0000);
  endtask : rd

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task add(input logic [1:0] q, input logic [8:0] n);
    add_stb <= 1'b1;
    add_q <= q;
    add_n <= n;
    @(posedge clk);
    add_stb <= 1'b0;
    @(posedge clk);
  endtask : add

  task pulse(input int n);
    repeat (n) begin
      parity_err <= 1'b1;
      @(posedge clk);
      parity_err <= 1'b0;
      @(posedge clk);
    end
  endtask : pulse

  // Result watcher: each read completion and each message takes a note
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite)
      chk("rdata", {pslverr, prdata}, exp_rd.size() ? exp_rd.pop_front() : 0);
    if (msg !== 3'h0)
      chk("msg", 33'(msg), exp_msg.size() ? 33'(exp_msg.pop_front()) : 0);
  end

  initial begin
    int i, k, n1, n2;
    void'($urandom(65538));
    cyc(3);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(`PTOER_OFF_PARITY_CNT, 33'h0);
    rd(`PTOER_OFF_TO_ENABLE, 33'h1);
    rd(`PTOER_OFF_TO_REPORT, 33'h2);
    rd(`PTOER_OFF_DROP_CNT, 33'h0);
    rd(`PTOER_OFF_WAKE_CTRL, 33'h3);
    rd(12'h4f0, 33'h1_0000_0000);
    wr(`PTOER_OFF_TO_ENABLE, 32'hffff_fffe);
    rd(`PTOER_OFF_TO_ENABLE, 33'h0);
    wr(`PTOER_OFF_TO_REPORT, 32'hffff_ffff);
    rd(`PTOER_OFF_TO_REPORT, 33'h3f);
    wr(`PTOER_OFF_DROP_CNT, 32'hffff_ffff);
    wr(12'h4f0, 32'h0000_0001);
    rd(`PTOER_OFF_DROP_CNT, 33'h0);
    $display("test registers done");
    for (int f = 0; f < 3; f++) begin
      for (int v = 0; v < 4; v++) begin
        wr(`PTOER_OFF_TO_REPORT, 32'(v) << (2 * f));
        if (v != 0) exp_msg.push_back(3'(1 << (v - 1)));
        timeout_status[f] <= 1'b1;
        cyc(6);
        timeout_status[f] <= 1'b0;
        cyc(2);
      end
    end
    chk("msg left", 33'(exp_msg.size()), 33'h0);
    $display("test reports done");
    n1 = $urandom_range(1, 9);
    n2 = $urandom_range(1, 9);
    add(2'h2, 9'(n2));
    cyc(8);
    chk("held", 33'(queue_head_expired), 33'h4);
    wr(`PTOER_OFF_TO_ENABLE, 32'h0000_0001);
    add(2'h0, 9'd300);
    add(2'h1, 9'(n1));
    i = 0;
    while (queue_head_expired !== 3'h0 && i < 2000) begin
      @(posedge clk);
      i++;
    end
    bound(i);
    cyc(3);
    rd(`PTOER_OFF_DROP_CNT, {9'h0, 8'(n2), 8'(n1), 8'hff});
    rd(`PTOER_OFF_DROP_CNT, 33'h0);
    $display("test drops done");
    k = $urandom_range(1, 40);
    pulse(k);
    rd(`PTOER_OFF_PARITY_CNT, 33'(k));
    rd(`PTOER_OFF_PARITY_CNT, 33'h0);
    pulse(260);
    rd(`PTOER_OFF_PARITY_CNT, 33'hff);
    $display("test parity done");
    wake_req <= 1'b1;
    beacon_req <= 1'b1;
    cyc(3);
    chk("wake on", {wake_oe_n, beacon_send}, 33'h1);
    wr(`PTOER_OFF_WAKE_CTRL, 32'h0000_0000);
    cyc(2);
    chk("wake off", {wake_oe_n, beacon_send, beacon_enable}, 33'h4);
    wr(`PTOER_OFF_WAKE_CTRL, 32'h0000_0003);
    wr(`PTOER_OFF_TO_REPORT, 32'h0000_0039);
    hot_reset <= 1'b1;
    @(posedge clk);
    hot_reset <= 1'b0;
    rd(`PTOER_OFF_TO_REPORT, 33'h39);
    rd(`PTOER_OFF_TO_ENABLE, 33'h1);
    rd(`PTOER_OFF_WAKE_CTRL, 33'h3);
    $display("test wake and sticky done");
    wake_in <= 1'b0;
    cyc(6);
    rd(`PTOER_OFF_WAKE_STATUS, 33'h0);
    wake_in <= 1'b1;
    cyc(6);
    rd(`PTOER_OFF_WAKE_STATUS, 33'h1);
    pulse(3);
    wr(`PTOER_OFF_TO_ENABLE, 32'h0000_0000);
    wr(`PTOER_OFF_WAKE_CTRL, 32'h0000_0001);
    fund_reset <= 1'b1;
    @(posedge clk);
    fund_reset <= 1'b0;
    @(posedge clk);
    chk("to en", 33'(timeout_enable), 33'h1);
    rd(`PTOER_OFF_PARITY_CNT, 33'h0);
    rd(`PTOER_OFF_TO_REPORT, 33'h2);
    rd(`PTOER_OFF_WAKE_CTRL, 33'h1);
    clk_en <= 1'b0;
    pulse(4);
    clk_en <= 1'b1;
    rd(`PTOER_OFF_PARITY_CNT, 33'h0);
    cyc(4);
    chk("rd left", 33'(exp_rd.size()), 33'h0);
    $display("test fund reset and freeze done");
    conclude();
  end
endmodule : ptoer_regs_tb
